// file: verilog/splph_pkg.sv
// Constants, register map and carrier types for the port power and
// hot-plug block. Assumes a 10 MHz core clock and a 32-bit bus.
package splph_pkg;

  // Clock rate and link recovery limits
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int PARTIAL_EXIT_US = 10;
  localparam int SLUMBER_EXIT_MS = 10;
  localparam int PARTIAL_EXIT_CYC = PARTIAL_EXIT_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int SLUMBER_EXIT_CYC = SLUMBER_EXIT_MS * (CLK_FREQ_HZ / 1_000);
  localparam int WAKE_CNT_W = 17;

  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_IS = 8'h04;
  localparam logic [7:0] OFS_IE = 8'h08;
  localparam logic [7:0] OFS_SSTS = 8'h0C;
  localparam logic [7:0] OFS_SCTL = 8'h10;
  localparam logic [7:0] OFS_SERR = 8'h14;
  localparam logic [7:0] OFS_CI = 8'h18;
  localparam logic [7:0] OFS_SACT = 8'h1C;
  localparam logic [7:0] OFS_GHC = 8'h20;
  localparam logic [7:0] OFS_DSTATE = 8'h24;

  // Field positions
  localparam int CMD_ST_BIT = 0;
  localparam int CMD_CCS_LSB = 8;
  localparam int CMD_CR_BIT = 15;
  localparam int CMD_ALPE_BIT = 26;
  localparam int CMD_ASP_BIT = 27;
  localparam int CMD_ICC_LSB = 28;
  localparam int IS_PCS_BIT = 6;
  localparam int IS_PRCS_BIT = 22;
  localparam int IE_PRCE_BIT = 22;
  localparam int SSTS_DET_LSB = 0;
  localparam int SSTS_IPM_LSB = 8;
  localparam int SCTL_IPM_LSB = 8;
  localparam int SERR_N_BIT = 16;
  localparam int SERR_X_BIT = 26;
  localparam int GHC_IE_BIT = 1;

  // Field codes
  localparam logic [3:0] DET_NONE = 4'h0;
  localparam logic [3:0] DET_PRESENT = 4'h1;
  localparam logic [3:0] DET_READY = 4'h3;
  localparam logic [3:0] IPM_NODEV = 4'h0;
  localparam logic [3:0] IPM_ACTIVE = 4'h1;
  localparam logic [3:0] IPM_PARTIAL = 4'h2;
  localparam logic [3:0] IPM_SLUMBER = 4'h6;
  localparam logic [3:0] ICC_ACTIVE = 4'h1;
  localparam logic [3:0] ICC_PARTIAL = 4'h2;
  localparam logic [3:0] ICC_SLUMBER = 4'h6;
  localparam logic [3:0] ALLOW_ALL = 4'h0;
  localparam logic [3:0] ALLOW_NO_PARTIAL = 4'h1;
  localparam logic [3:0] ALLOW_NO_SLUMBER = 4'h2;
  localparam logic [1:0] DSTATE_D0 = 2'h0;
  localparam logic [1:0] DSTATE_D3 = 2'h3;

  // Interface power state machine, Gray along host Partial entry and wake
  typedef enum logic [2:0] {
    PM_ACTIVE = 3'b000,
    PM_HREQ = 3'b001,
    PM_PARTIAL = 3'b011,
    PM_SLUMBER = 3'b111,
    PM_WAKE = 3'b010
  } splph_pm_e;

  // Signals arriving from the phy side
  typedef struct packed {
    logic phyReady;
    logic cominit;
    logic devReqPartial;
    logic devReqSlumber;
    logic pmAck;
    logic pmNack;
    logic pmEvent;
  } splph_link_in_s;

  // Signals driven toward the phy side
  typedef struct packed {
    logic pmReqPartial;
    logic pmReqSlumber;
    logic pmAck;
    logic pmNack;
    logic comwake;
  } splph_link_out_s;

endpackage

// file: verilog/splph_port.sv
// Per-port interface power and hot-plug control with a Wishbone slave.
// Assumes phy inputs are asynchronous; link-layer inputs share mclk.
//
// Overview of operation
// - Phy ready edges, low-power entry and exit on phy ready set the ready-change diag
// - No removal reported while the link rests in Partial or Slumber
// - Connect change halts the command list and clears running
// - Issue, queued and current slot stay intact after the halt
// - Function supports D0 and D3 only; D1 and D2 undefined
// - Partial recovers within 10 us, Slumber within 10 ms
// - Any power management event wakes the interface
// - Low-power entry negotiated by request with ack or nack
// - Current interface power state readable while the function is in D0
// - Device requests judged by pm allow; nack when a frame is pending
// - State request write acted on only while the link is idle
// - Never move directly between Partial and Slumber on a request
// - Wake request to active bounded by the recovery time
// - Detect state becomes 3h when phy ready rises
// - Ready-change status mirrors the ready-change diag
// - Connect-change status mirrors the insertion diag
`timescale 1ns/1ps

module splph_port
  import splph_pkg::*;
#(
  parameter int SlumberExitCycles = SLUMBER_EXIT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Link layer, same clock
  input wire logic linkIdle,
  input wire logic framePending,
  input wire logic cmdDone,
  // Phy side
  input wire splph_link_in_s linkIn,
  output splph_link_out_s linkOut,
  // Port status
  output logic xferEnable,
  output logic irqReq
);

  // Whole port state in one record
  typedef struct packed {
    splph_link_in_s sync1;
    splph_link_in_s sync2;
    splph_link_in_s prev;
    splph_pm_e pm;
    logic [WAKE_CNT_W-1:0] wakeCnt;
    logic wakeSlumber;
    splph_link_out_s lo;
    logic st;
    logic halt;
    logic alpe;
    logic asp;
    logic prce;
    logic gie;
    logic [3:0] ipmAllow;
    logic [3:0] det;
    logic diagN;
    logic diagX;
    logic [31:0] ci;
    logic [31:0] sact;
    logic [4:0] ccs;
    logic [1:0] dstate;
    logic ack;
    logic [31:0] dat;
    logic irq;
    logic xfer;
  } splph_state_s;

  splph_state_s state_reg;
  splph_state_s state_next;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                            input logic [31:0] wr,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Lowest set slot, zero when none
  function automatic logic [4:0] lowSlot(input logic [31:0] bits);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (bits[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    splph_state_s n;
    logic req;
    logic wr;
    logic inD0;
    logic [31:0] cmdWord;
    logic [31:0] wrWord;
    logic [3:0] icc;
    logic iccWr;
    logic phyRise;
    logic phyFall;
    logic cr;
    logic hostReq;
    logic hostSlumber;
    logic devOk;
    logic [3:0] ipmCode;
    logic [WAKE_CNT_W-1:0] wakeLimit;
    n = state_reg;
    req = wb_cyc_i & wb_stb_i & ~state_reg.ack;
    wr = req & wb_we_i;
    inD0 = (state_reg.dstate == DSTATE_D0);
    cmdWord = 32'h0000_0000;
    wrWord = 32'h0000_0000;
    icc = 4'h0;
    iccWr = 1'b0;
    hostReq = 1'b0;
    hostSlumber = 1'b0;
    devOk = 1'b0;
    ipmCode = IPM_NODEV;
    wakeLimit = state_reg.wakeSlumber ? WAKE_CNT_W'(SlumberExitCycles - 1)
                                      : WAKE_CNT_W'(PARTIAL_EXIT_CYC - 1);

    // Two-stage synchroniser, edges taken from the second stage only
    n.sync1 = linkIn;
    n.sync2 = state_reg.sync1;
    n.prev = state_reg.sync2;
    phyRise = state_reg.sync2.phyReady & ~state_reg.prev.phyReady;
    phyFall = ~state_reg.sync2.phyReady & state_reg.prev.phyReady;

    // One-cycle primitives fall back by default
    n.lo.pmAck = 1'b0;
    n.lo.pmNack = 1'b0;

    // Bus answer one cycle after the request, dropped the cycle after
    n.ack = req;
    cr = state_reg.st & ~state_reg.halt;

    ipmCode = ipmOf(state_reg.pm);
    if (state_reg.det != DET_READY) begin
      ipmCode = IPM_NODEV;
    end

    // Register reads; in D3 only the power state register answers data
    n.dat = 32'h0000_0000;
    if (req && !wb_we_i && (inD0 || wb_adr_i == OFS_DSTATE)) begin
      case (wb_adr_i)
        OFS_CMD: begin
          n.dat[CMD_ST_BIT] = state_reg.st;
          n.dat[CMD_CCS_LSB +: 5] = state_reg.ccs;
          n.dat[CMD_CR_BIT] = cr;
          n.dat[CMD_ALPE_BIT] = state_reg.alpe;
          n.dat[CMD_ASP_BIT] = state_reg.asp;
        end
        OFS_IS: begin
          n.dat[IS_PCS_BIT] = state_reg.diagX;
          n.dat[IS_PRCS_BIT] = state_reg.diagN;
        end
        OFS_IE: n.dat[IE_PRCE_BIT] = state_reg.prce;
        OFS_SSTS: begin
          n.dat[SSTS_DET_LSB +: 4] = state_reg.det;
          n.dat[SSTS_IPM_LSB +: 4] = ipmCode;
        end
        OFS_SCTL: n.dat[SCTL_IPM_LSB +: 4] = state_reg.ipmAllow;
        OFS_SERR: begin
          n.dat[SERR_N_BIT] = state_reg.diagN;
          n.dat[SERR_X_BIT] = state_reg.diagX;
        end
        OFS_CI: n.dat = state_reg.ci;
        OFS_SACT: n.dat = state_reg.sact;
        OFS_GHC: n.dat[GHC_IE_BIT] = state_reg.gie;
        OFS_DSTATE: n.dat[1:0] = state_reg.dstate;
        default: n.dat = 32'h0000_0000;
      endcase
    end

    // Register writes; in D3 all but the power state register are dropped
    if (wr && (inD0 || wb_adr_i == OFS_DSTATE)) begin
      case (wb_adr_i)
        OFS_CMD: begin
          cmdWord[CMD_ST_BIT] = state_reg.st;
          cmdWord[CMD_ALPE_BIT] = state_reg.alpe;
          cmdWord[CMD_ASP_BIT] = state_reg.asp;
          wrWord = laneMerge(cmdWord, wb_dat_i, wb_sel_i);
          n.st = wrWord[CMD_ST_BIT];
          n.alpe = wrWord[CMD_ALPE_BIT];
          n.asp = wrWord[CMD_ASP_BIT];
          icc = wrWord[CMD_ICC_LSB +: 4];
          iccWr = wb_sel_i[3] & (icc != 4'h0);
          // Clearing start empties the list and lifts the halt
          if (!wrWord[CMD_ST_BIT]) begin
            n.ci = 32'h0000_0000;
            n.sact = 32'h0000_0000;
            n.halt = 1'b0;
          end
        end
        OFS_IE: begin
          wrWord = laneMerge({9'h000, state_reg.prce, 22'h000000},
                             wb_dat_i, wb_sel_i);
          n.prce = wrWord[IE_PRCE_BIT];
        end
        OFS_SCTL: begin
          wrWord = laneMerge({20'h00000, state_reg.ipmAllow, 8'h00},
                             wb_dat_i, wb_sel_i);
          n.ipmAllow = wrWord[SCTL_IPM_LSB +: 4];
        end
        OFS_SERR: begin
          // Write one to clear; the status view has no store of its own
          wrWord = laneMerge(32'h0000_0000, wb_dat_i, wb_sel_i);
          if (wrWord[SERR_N_BIT]) n.diagN = 1'b0;
          if (wrWord[SERR_X_BIT]) n.diagX = 1'b0;
        end
        OFS_CI: begin
          if (cr) n.ci = state_reg.ci | laneMerge(32'h0000_0000,
                                                   wb_dat_i, wb_sel_i);
        end
        OFS_SACT: begin
          if (cr) n.sact = state_reg.sact | laneMerge(32'h0000_0000,
                                                       wb_dat_i, wb_sel_i);
        end
        OFS_GHC: begin
          wrWord = laneMerge({30'h00000000, state_reg.gie, 1'b0},
                             wb_dat_i, wb_sel_i);
          n.gie = wrWord[GHC_IE_BIT];
        end
        OFS_DSTATE: begin
          // Only D0 and D3 exist; other codes leave the state alone
          if (wb_sel_i[0] && (wb_dat_i[1:0] == DSTATE_D0 ||
                              wb_dat_i[1:0] == DSTATE_D3)) begin
            n.dstate = wb_dat_i[1:0];
          end
        end
        default: n.st = n.st;
      endcase
    end

    // Command slot tracking while running
    if (cr && cmdDone) begin
      n.ci[state_reg.ccs] = 1'b0;
    end
    if (cr && n.ci != 32'h0000_0000) begin
      n.ccs = lowSlot(n.ci);
    end

    // Insertion: COMINIT sets the connect diag after any clear
    if (state_reg.sync2.cominit && !state_reg.prev.cominit) begin
      n.diagX = 1'b1;
      n.det = DET_PRESENT;
    end
    // Halt the list on a new connect change; slot state kept
    if (n.diagX && !state_reg.diagX) begin
      n.halt = 1'b1;
    end
    if (phyRise) begin
      n.det = DET_READY;
    end
    // Phy edges count only while the link is meant to carry signal
    if ((phyRise || phyFall) &&
        (state_reg.pm == PM_ACTIVE || state_reg.pm == PM_HREQ)) begin
      n.diagN = 1'b1;
    end
    if (phyFall && state_reg.pm == PM_ACTIVE) begin
      n.det = DET_PRESENT;
    end

    // Host-side low-power request; aggressive entry outranks software
    if (state_reg.alpe && state_reg.sact == 32'h0000_0000 &&
        state_reg.ci != 32'h0000_0000 && n.ci == 32'h0000_0000) begin
      hostReq = 1'b1;
      hostSlumber = state_reg.asp;
    end else if (iccWr && linkIdle &&
                 (icc == ICC_PARTIAL || icc == ICC_SLUMBER)) begin
      hostReq = 1'b1;
      hostSlumber = (icc == ICC_SLUMBER);
    end

    // Interface power state machine
    unique case (state_reg.pm)
      PM_ACTIVE: begin
        if (hostReq && state_reg.det == DET_READY) begin
          n.pm = PM_HREQ;
          n.wakeSlumber = hostSlumber;
          n.lo.pmReqPartial = ~hostSlumber;
          n.lo.pmReqSlumber = hostSlumber;
        end else if ((state_reg.sync2.devReqPartial &&
                      !state_reg.prev.devReqPartial) ||
                     (state_reg.sync2.devReqSlumber &&
                      !state_reg.prev.devReqSlumber)) begin
          hostSlumber = state_reg.sync2.devReqSlumber;
          devOk = (state_reg.ipmAllow == ALLOW_ALL) ||
                  (state_reg.ipmAllow == ALLOW_NO_PARTIAL && hostSlumber) ||
                  (state_reg.ipmAllow == ALLOW_NO_SLUMBER && !hostSlumber);
          if (devOk && !framePending) begin
            n.lo.pmAck = 1'b1;
            n.pm = hostSlumber ? PM_SLUMBER : PM_PARTIAL;
            n.wakeSlumber = hostSlumber;
            n.diagN = 1'b1;
          end else begin
            n.lo.pmNack = 1'b1;
          end
        end
      end
      PM_HREQ: begin
        if (state_reg.sync2.pmAck) begin
          n.pm = state_reg.wakeSlumber ? PM_SLUMBER : PM_PARTIAL;
          n.lo.pmReqPartial = 1'b0;
          n.lo.pmReqSlumber = 1'b0;
          n.diagN = 1'b1;
        end else if (state_reg.sync2.pmNack) begin
          n.pm = PM_ACTIVE;
          n.lo.pmReqPartial = 1'b0;
          n.lo.pmReqSlumber = 1'b0;
        end
      end
      PM_PARTIAL, PM_SLUMBER: begin
        // A request for the other low state is ignored here
        if ((iccWr && linkIdle && icc == ICC_ACTIVE) || framePending ||
            state_reg.sync2.pmEvent || phyRise) begin
          n.pm = PM_WAKE;
          n.lo.comwake = 1'b1;
          n.wakeCnt = '0;
        end
      end
      PM_WAKE: begin
        // Wake ends on phy ready or at the recovery bound
        n.wakeCnt = state_reg.wakeCnt + 1'b1;
        if (state_reg.sync2.phyReady) begin
          n.pm = PM_ACTIVE;
          n.lo.comwake = 1'b0;
          n.diagN = 1'b1;
          n.det = DET_READY;
        end else if (state_reg.wakeCnt >= wakeLimit) begin
          n.pm = PM_ACTIVE;
          n.lo.comwake = 1'b0;
          n.det = DET_PRESENT;
        end
      end
      default: n.pm = PM_ACTIVE;
    endcase

    // Registered port outputs; no interrupt while in D3
    n.irq = n.diagN & n.prce & n.gie & (n.dstate == DSTATE_D0);
    n.xfer = n.st & ~n.halt & (n.pm == PM_ACTIVE) & (n.det == DET_READY);
    state_next = n;
  end

  // Status code per power state; request and wake still read as active
  function automatic logic [3:0] ipmOf(input splph_pm_e pm);
    return (pm == PM_PARTIAL) ? IPM_PARTIAL :
           (pm == PM_SLUMBER) ? IPM_SLUMBER : IPM_ACTIVE;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
      state_reg.pm <= PM_ACTIVE;
      state_reg.det <= DET_NONE;
      state_reg.dstate <= DSTATE_D0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_o = state_reg.dat;
  assign wb_ack_o = state_reg.ack;
  assign linkOut = state_reg.lo;
  assign xferEnable = state_reg.xfer;
  assign irqReq = state_reg.irq;

endmodule

// file: testbench/splph_port_sva.sv
// Checker for the port power and hot-plug block.
// Assumes the bench holds device requests several cycles.
`timescale 1ns/1ps

module splph_port_sva
  import splph_pkg::*;
#(
  parameter int SlumberExitCycles = 200
) (
  // Clock, reset, bus
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Link and status
  input wire logic linkIdle,
  input wire logic framePending,
  input wire logic cmdDone,
  input wire splph_link_in_s linkIn,
  input wire splph_link_out_s linkOut,
  input wire logic xferEnable,
  input wire logic irqReq
);
  localparam int WakeMax = SlumberExitCycles + 8;
  logic anyReq;
  logic iccWr;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////
  // Decoded helpers
  assign anyReq = linkOut.pmReqPartial || linkOut.pmReqSlumber;
  assign iccWr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[3] &&
                 wb_adr_i == OFS_CMD && wb_dat_i[31:28] != 4'h0;

  ////////////////////////////////////////////////////////////////////////
  // Properties
  ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("no ack after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  rdata_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  req_hold_a: assert property ($fell(anyReq) |->
    $past(linkIn.pmAck || linkIn.pmNack, 2)) else $error("request dropped");
  dev_answer_a: assert property (linkOut.pmAck || linkOut.pmNack |->
    !(linkOut.pmAck && linkOut.pmNack) &&
    $past(linkIn.devReqPartial || linkIn.devReqSlumber, 3))
    else $error("answer without device request");
  wake_bound_a: assert property ($rose(linkOut.comwake)
    |-> ##[1:WakeMax] !linkOut.comwake) else $error("wake too long");
  halt_connect_a: assert property ($rose(linkIn.cominit)
    |-> ##5 !xferEnable [*8]) else $error("no halt on connect");
  icc_busy_a: assert property (iccWr && !linkIdle && !anyReq
    |=> !anyReq [*6]) else $error("request acted while busy");
  entry_active_a: assert property ($rose(anyReq)
    |-> $past(linkIn.phyReady, 3) && !linkOut.comwake)
    else $error("entry not from active");

  // Main scenarios
  wake_c: cover property ($fell(linkOut.comwake));
  dev_ack_c: cover property (linkOut.pmAck);
  irq_c: cover property (irqReq);
endmodule

bind splph_port splph_port_sva #(.SlumberExitCycles(SlumberExitCycles))
  i_splph_port_sva (.mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .linkIdle(linkIdle), .framePending(framePending),
  .cmdDone(cmdDone), .linkIn(linkIn), .linkOut(linkOut),
  .xferEnable(xferEnable), .irqReq(irqReq));

// file: testbench/splph_dev_model.sv
// Storage device across the link, behavioural.
// Assumes bench controls presence, refusal and wake delay.
`timescale 1ns/1ps

module splph_dev_model
  import splph_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Bench controls
  input wire logic present,
  input wire logic refuse,
  input wire logic [7:0] wakeDelay,
  input wire logic [1:0] devReq,
  input wire logic cominitPin,
  input wire logic pmEventPin,
  // Link
  input wire splph_link_out_s linkOut,
  output splph_link_in_s linkIn
);
  logic lowPower;
  logic waking;
  logic ackReg;
  logic nackReg;
  logic [7:0] wakeCnt;
  logic hostReq;

  ////////////////////////////////////////////////////////////////////////
  // Primitive held until host withdraws; phy off while resting
  assign hostReq = linkOut.pmReqPartial || linkOut.pmReqSlumber;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      {lowPower, waking, ackReg, nackReg} <= 4'h0;
      wakeCnt <= 8'h00;
    end else begin
      ackReg <= hostReq && !refuse;
      nackReg <= hostReq && refuse;
      if ((ackReg && !hostReq) || linkOut.pmAck) begin
        lowPower <= 1'b1;
      end
      if (linkOut.comwake && lowPower) begin
        waking <= 1'b1;
      end
      // Wake keeps counting even if host gives up
      if (waking) begin
        wakeCnt <= wakeCnt + 8'h01;
      end
      if (waking && wakeCnt == wakeDelay) begin
        {lowPower, waking} <= 2'b00;
        wakeCnt <= 8'h00;
      end
    end
  end

  // Phy ready drops with removal or low power
  assign linkIn = '{phyReady: present && !lowPower, cominit: cominitPin,
    devReqPartial: devReq[1], devReqSlumber: devReq[0], pmAck: ackReg,
    pmNack: nackReg, pmEvent: pmEventPin};
endmodule

// file: testbench/splph_port_tb_top.sv
// Bench for the port power and hot-plug block.
// Assumes design package and checker bind are compiled first.
`timescale 1ns/1ps

module splph_port_tb_top
  import splph_pkg::*;
;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic linkIdle = 1'b0;
  logic framePending = 1'b0;
  logic present = 1'b0;
  logic [7:0] wakeDelay = 8'h14;
  logic [1:0] devReq = 2'b00;
  logic cominitPin = 1'b0;
  logic pmEventPin = 1'b0;
  splph_link_in_s linkIn;
  splph_link_out_s linkOut;
  logic xferEnable;
  logic irqReq;
  logic [31:0] errors = 32'h0;
  logic [31:0] compares = 32'h0;
  logic [31:0] ackSeen = 32'h0;
  logic [31:0] nackSeen = 32'h0;
  logic cntClr = 1'b0;
  logic refuse = 1'b0;
  logic cmdDone = 1'b0;
  logic [1:0] reqTab [5] = '{2'b10, 2'b01, 2'b01, 2'b10, 2'b10};
  logic [3:0] allowTab [5] = '{4'h1, 4'h2, 4'h3, 4'h0, 4'h0};
  logic pendTab [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

  always #50 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////
  // Design and device
  splph_port #(.SlumberExitCycles(200)) i_splph_port (.mclk(mclk),
    .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .linkIdle(linkIdle), .framePending(framePending), .cmdDone(cmdDone),
    .linkIn(linkIn), .linkOut(linkOut), .xferEnable(xferEnable),
    .irqReq(irqReq));
  splph_dev_model i_splph_dev_model (.mclk(mclk), .resetn(resetn),
    .present(present), .refuse(refuse), .wakeDelay(wakeDelay),
    .devReq(devReq), .cominitPin(cominitPin), .pmEventPin(pmEventPin),
    .linkOut(linkOut), .linkIn(linkIn));

  // Count answer pulses to device requests; one driver, cleared on request
  always @(posedge mclk) begin
    if (cntClr) begin
      ackSeen <= 32'h0;
      nackSeen <= 32'h0;
    end else begin
      if (linkOut.pmAck === 1'b1) ackSeen <= ackSeen + 32'h1;
      if (linkOut.pmNack === 1'b1) nackSeen <= nackSeen + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 32'h1;
    if (seen !== exp) begin
      errors = errors + 32'h1;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic cycle; waits for ack up to 50 cycles, bounded by count
  task automatic wbCycle(input logic [7:0] a, input logic [31:0] d,
                         input logic we, output logic [31:0] rd);
    int n;
    n = 0;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i <= we;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    check({31'h0, wb_ack_o}, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    wbCycle(a, d, 1'b1, x);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp,
                       input logic [31:0] mask);
    logic [31:0] x;
    wbCycle(a, 32'h0, 1'b0, x);
    check(x & mask, exp);
  endtask

  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 32'h0 && compares != 32'h0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    settle(20000);
    errors = errors + 32'h1;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    settle(12);
    resetn <= 1'b1;
    settle(1);
    rdChk(OFS_SSTS, 32'h0, ALL);
    rdChk(8'h30, 32'h0, ALL);
    present <= 1'b1;
    settle(8);
    rdChk(OFS_SSTS, 32'h0000_0103, ALL);
    rdChk(OFS_SERR, 32'h0001_0000, 32'h0001_0000);
    rdChk(OFS_IS, 32'h0040_0000, 32'h0040_0000);
    wr(OFS_SCTL, 32'h0000_0300);
    wr(OFS_GHC, 32'h2);
    wr(OFS_IE, 32'h0040_0000);
    settle(3);
    check({31'h0, irqReq}, 32'h1);
    wr(OFS_IE, 32'h0);
    wr(OFS_SCTL, 32'h0);
    settle(3);
    check({31'h0, irqReq}, 32'h0);
    wr(OFS_SERR, 32'h0001_0000);
    rdChk(OFS_IS, 32'h0, 32'h0040_0000);
    // Partial entry refused while busy, then taken
    wr(OFS_CMD, 32'h2000_0000);
    settle(10);
    rdChk(OFS_SSTS, 32'h0000_0103, ALL);
    linkIdle <= 1'b1;
    wr(OFS_CMD, 32'h2000_0000);
    settle(15);
    rdChk(OFS_SSTS, 32'h0000_0203, ALL);
    rdChk(OFS_SERR, 32'h0001_0000, 32'h0001_0000);
    wr(OFS_SERR, 32'h0001_0000);
    present <= 1'b0;
    wr(OFS_CMD, 32'h6000_0000);
    settle(15);
    rdChk(OFS_SSTS, 32'h0000_0203, ALL);
    rdChk(OFS_SERR, 32'h0, 32'h0001_0000);
    present <= 1'b1;
    wr(OFS_CMD, 32'h1000_0000);
    settle(60);
    rdChk(OFS_SSTS, 32'h0000_0103, ALL);
    // Slumber, event wake with a device too slow
    wr(OFS_CMD, 32'h6000_0000);
    settle(15);
    rdChk(OFS_SSTS, 32'h0000_0603, ALL);
    wakeDelay <= 8'hFA;
    pmEventPin <= 1'b1;
    settle(6);
    pmEventPin <= 1'b0;
    settle(215);
    rdChk(OFS_SSTS, 32'h0000_0001, ALL);
    settle(60);
    rdChk(OFS_SSTS, 32'h0000_0103, ALL);
    wakeDelay <= 8'h14;
    // Device requests judged by allow code and pending frame
    for (int i = 0; i < 5; i++) begin
      wr(OFS_SCTL, {20'h0, allowTab[i], 8'h00});
      framePending <= pendTab[i];
      cntClr <= 1'b1;
      devReq <= reqTab[i];
      settle(1);
      cntClr <= 1'b0;
      settle(9);
      devReq <= 2'b00;
      framePending <= 1'b0;
      check(ackSeen, {31'h0, i == 4});
      check(nackSeen, {31'h0, i != 4});
    end
    settle(10);
    rdChk(OFS_SSTS, 32'h0000_0203, ALL);
    wr(OFS_CMD, 32'h1000_0000);
    settle(60);
    // Device refuses a host request; link stays active
    refuse <= 1'b1;
    wr(OFS_CMD, 32'h2000_0000);
    settle(10);
    rdChk(OFS_SSTS, 32'h0000_0103, ALL);
    refuse <= 1'b0;
    // Connect change halts the list, keeps slots
    wr(OFS_CMD, 32'h0000_0001);
    wr(OFS_CI, 32'h0000_0005);
    wr(OFS_SACT, 32'h0000_0003);
    settle(3);
    check({31'h0, xferEnable}, 32'h1);
    // Slot 0 completes, so the current slot moves on to 2
    cmdDone <= 1'b1;
    settle(1);
    cmdDone <= 1'b0;
    cominitPin <= 1'b1;
    settle(8);
    cominitPin <= 1'b0;
    check({31'h0, xferEnable}, 32'h0);
    rdChk(OFS_CMD, 32'h0000_0201, ALL);
    rdChk(OFS_CI, 32'h0000_0004, ALL);
    rdChk(OFS_SACT, 32'h0000_0003, ALL);
    rdChk(OFS_IS, 32'h0000_0040, 32'h0000_0040);
    wr(OFS_CMD, 32'h0);
    rdChk(OFS_SACT, 32'h0, ALL);
    // Function in D3 hides port registers
    wr(OFS_DSTATE, {30'h0, DSTATE_D3});
    rdChk(OFS_SSTS, 32'h0, ALL);
    rdChk(OFS_DSTATE, 32'h3, ALL);
    wr(OFS_DSTATE, 32'h0);
    // Insertion left detect at present; no new phy ready since then
    rdChk(OFS_SSTS, 32'h0000_0001, ALL);
    report_and_stop();
  end
endmodule
